// File: program_sequencer_stack_bench.sv
`timescale 1ns/1ps
module program_sequencer_stack_bench;
   localparam [7:0] jmp = 8'h01, cal = 8'h02, ret = 8'h04, rti = 8'h08;
   localparam [7:0] skp = 8'h10, tbc = 8'h20, tbl = 8'h40, hlt = 8'h80;
   reg         clk_i    = 1'b0;
   reg         resetn_i = 1'b0;
   reg  [7:0]  op       = 8'h00;
   reg  [11:0] tgt      = 12'h000;
   reg  [7:0]  ra       = 8'h00;
   reg  [7:0]  wd       = 8'h00;
   reg         rw       = 1'b0;
   reg         rr       = 1'b0;
   reg  [5:0]  req      = 6'h00;
   reg         gset     = 1'b0;
   reg         wake     = 1'b0;
   reg  [5:0]  acks     = 6'h00;
   wire [11:0] addr;
   wire [14:0] rd, ins;
   wire [3:0]  ph;
   wire [7:0]  rdat, tlo;
   wire [5:0]  ack;
   wire        valid, hit, tv, gie, halted;
   integer     n_errors    = 0;
   integer     comparisons = 0;
   integer     i, n;
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) acks <= acks | ack;
   pss_rom_model u_pss_rom_model (.addr_i(addr), .data_o(rd));
   pss_program_sequencer #(.SST_CYCLES(8)) u_pss_program_sequencer (
      .clk_i(clk_i), .resetn_i(resetn_i), .rom_addr_o(addr), .rom_data_i(rd), .instr_o(ins),
      .instr_valid_o(valid), .phase_o(ph), .op_jump_i(op[0]), .op_call_i(op[1]),
      .return_from_call_i(op[2]), .return_from_interrupt_i(op[3]), .op_skip_i(op[4]),
      .table_read_current_page_i(op[5]), .table_read_last_page_i(op[6]), .op_halt_i(op[7]),
      .target_i(tgt), .reg_addr_i(ra), .reg_wr_i(rw), .reg_rd_i(rr), .reg_wdata_i(wd),
      .reg_rdata_o(rdat), .reg_hit_o(hit), .tbl_low_o(tlo), .tbl_low_valid_o(tv),
      .irq_req_i(req), .irq_en_i(6'h3F), .gie_set_i(gset), .gie_clr_i(1'b0),
      .irq_ack_o(ack), .global_irq_enable_o(gie), .wake_i(wake), .halted_o(halted));
   task check(input [14:0] got, input [14:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("Mismatches %0d of %0d comparisons", n_errors, comparisons);
         if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Parks on the falling edge in the last phase of a real instruction
   task sync;
      begin
         n = 0;
         while (!(ph[3] === 1'b1 && valid === 1'b1) && n < 200) begin
            @(negedge clk_i);
            n = n + 1;
         end
      end
   endtask
   task step(input [7:0] o, input [11:0] t);
      begin
         sync;
         op = o;
         tgt = t;
         @(negedge clk_i);
         op = 8'h00;
      end
   endtask
   task see(input [11:0] a);
      begin
         sync;
         check(ins, {3'h5, a});
         @(negedge clk_i);
      end
   endtask
   task rreg(input [7:0] a, input [7:0] e);
      begin
         ra = a;
         rr = 1'b1;
         @(negedge clk_i);
         rr = 1'b0;
         check(rdat, e);
         check(hit, a >= 8'h06 && a <= 8'h08);
      end
   endtask
   task wreg(input [7:0] a, input [7:0] d);
      begin
         ra = a;
         wd = d;
         rw = 1'b1;
         @(negedge clk_i);
         rw = 1'b0;
      end
   endtask
   task tbl_read(input [7:0] o, input [7:0] hi);
      begin
         step(o, 12'h000);
         while (tv !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n = n + 1;
         end
         check(tlo, 8'h5A);
         rreg(8'h08, hi);
      end
   endtask
   task t_flow;
      begin
         see(12'h000);
         see(12'h001);
         step(jmp, 12'h123);
         see(12'h123);
         step(jmp, 12'hFFF);
         see(12'hFFF);
         see(12'h000);
         step(skp, 12'h000);
         see(12'h003);
         step(jmp, 12'h3F0);
         sync;
         wreg(8'h06, 8'h45);
         see(12'h345);
         wreg(8'h07, 8'h5A);
         tbl_read(tbc, 8'h53);
         see(12'h347);
         wreg(8'h08, 8'hFF);
         rreg(8'h08, 8'h53);
         rreg(8'h20, 8'h00);
         tbl_read(tbl, 8'h5F);
      end
   endtask
   task t_stack;
      begin
         for (i = 1; i <= 7; i = i + 1)
            step(cal, {i[3:0], 8'h00});
         see(12'h700);
         gset = 1'b1;
         @(negedge clk_i);
         gset = 1'b0;
         acks = 6'h00;
         req = 6'h01;
         see(12'h701);
         see(12'h702);
         check(acks, 6'h00);
         step(ret, 12'h000);
         see(12'h004);
         check(acks, 6'h01);
         check(gie, 1'b0);
         req = 6'h00;
         step(rti, 12'h000);
         check(gie, 1'b1);
         // Oldest address was overwritten by the seventh call
         for (i = 6; i >= 1; i = i - 1) begin
            see({i[3:0], 8'h01});
            step(ret, 12'h000);
         end
         // Return on an empty stack lands on the slot that replaced the lost entry
         see(12'h601);
      end
   endtask
   task t_vec;
      begin
         for (i = 0; i < 6; i = i + 1) begin
            acks = 6'h00;
            sync;
            req = 6'h01 << i;
            @(negedge clk_i);
            see({i[9:0] + 10'h001, 2'b00});
            check(acks, 6'h01 << i);
            req = 6'h00;
            step(rti, 12'h000);
         end
      end
   endtask
   task t_halt;
      begin
         step(hlt, 12'h000);
         repeat (2) @(negedge clk_i);
         check(halted, 1'b1);
         wake = 1'b1;
         @(negedge clk_i);
         wake = 1'b0;
         n = 0;
         while (ph === 4'h0 && n < 50) begin
            @(negedge clk_i);
            n = n + 1;
         end
         check(n >= 7 && n <= 9, 1'b1);
      end
   endtask
   initial begin
      repeat (8) @(negedge clk_i);
      check(addr, 12'h000);
      resetn_i = 1'b1;
      t_flow;
      t_stack;
      t_vec;
      t_halt;
      end_of_test;
   end
   initial begin
      #(25 * 4000);
      n_errors = n_errors + 1;
      end_of_test;
   end
endmodule

// File: pss_checker_sva.sv
`timescale 1ns/1ps
module pss_checker (
   // Watched ports
   input wire        clk_i,
   input wire        resetn_i,
   input wire [11:0] rom_addr_o,
   input wire [14:0] instr_o,
   input wire        instr_valid_o,
   input wire [3:0]  phase_o,
   input wire        op_jump_i,
   input wire        op_halt_i,
   input wire        return_from_interrupt_i,
   input wire [11:0] target_i,
   input wire [5:0]  irq_ack_o,
   input wire        global_irq_enable_o,
   input wire        halted_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire ex3 = phase_o[3] && instr_valid_o;
   chk_phase_step: assert property (phase_o == 4'h1 |=> phase_o == 4'h2)
      else $error("phase did not advance");
   chk_phase_wrap: assert property (phase_o == 4'h8 && !(ex3 && op_halt_i) |=> phase_o == 4'h1)
      else $error("cycle did not restart");
   chk_valid_hold: assert property (instr_valid_o && !phase_o[3] |=> instr_valid_o && $stable(instr_o))
      else $error("instruction changed mid cycle");
   // Address moves only on the last phase edge
   chk_addr_hold: assert property (!phase_o[3] && phase_o != 4'h0 |=> $stable(rom_addr_o))
      else $error("fetch address moved mid cycle");
   chk_jump_tgt: assert property (ex3 && op_jump_i |=>
      !instr_valid_o && rom_addr_o == $past(target_i) ##4 instr_valid_o)
      else $error("jump target or dummy cycle wrong");
   chk_ack_pulse: assert property (|irq_ack_o |->
      $onehot(irq_ack_o) && !global_irq_enable_o ##1 irq_ack_o == 6'h00)
      else $error("acknowledge pulse wrong");
   chk_return_from_interrupt_gie: assert property (ex3 && return_from_interrupt_i |=>
      global_irq_enable_o && !instr_valid_o)
      else $error("interrupt return left enable low");
   chk_halt_stop: assert property (ex3 && op_halt_i |=> halted_o && phase_o == 4'h0)
      else $error("halt did not stop phases");
endmodule
bind pss_program_sequencer pss_checker u_pss_checker (
   .clk_i(clk_i), .resetn_i(resetn_i), .rom_addr_o(rom_addr_o), .instr_o(instr_o),
   .instr_valid_o(instr_valid_o), .phase_o(phase_o), .op_jump_i(op_jump_i), .op_halt_i(op_halt_i),
   .return_from_interrupt_i(return_from_interrupt_i), .target_i(target_i), .irq_ack_o(irq_ack_o),
   .global_irq_enable_o(global_irq_enable_o), .halted_o(halted_o));

// File: pss_map.vh
// Function
// - Four system clocks per instruction cycle
// - Fetch overlaps execute; transfers add dummy cycle
// - Twelve-bit counter, increments after each fetch
// - True skip discards fetched word, PC+2
// - Low-byte write jumps within current page
// - Transfers load target instead of incrementing
// - Reset clears counter to 000H
// - External inputs vector 004H and 008H
// - Counter overflows vector 00CH and 010H
// - Time base 014H, real-time clock 018H
// - Program memory 4096 x 15 words
// - Table address: page nibble plus pointer
// - Table high seven bits, top reads zero
// - Table read takes two cycles
// - Six-entry hidden return stack, push/pop
// - Reset points stack index at top
// - Full stack withholds interrupt acknowledge
// - Call on full stack drops oldest
// - Wake from halt waits 1024 clocks
// - Interrupt return sets global enable
// - Acknowledge clears global enable and flag
`ifndef PSS_MAP_VH
`define PSS_MAP_VH

`define PSS_PC_W          12
`define PSS_ROM_W         15
`define PSS_ADDR_PC_LOW   8'h06
`define PSS_ADDR_TBL_PTR  8'h07
`define PSS_ADDR_TBL_HIGH 8'h08
`define PSS_TBL_PTR_RST   8'h00
`define PSS_TBL_HIGH_RST  8'h00
`define PSS_LAST_PAGE     4'hF
`define PSS_PHASE_LAST    2'h3
`define PSS_STACK_DEPTH   6
`define PSS_NUM_IRQ       6

`define PSS_VEC_RESET     12'h000
`define PSS_VEC_EXT0      12'h004
`define PSS_VEC_EXT1      12'h008
`define PSS_VEC_TMR0      12'h00C
`define PSS_VEC_TMR1      12'h010
`define PSS_VEC_TBASE     12'h014
`define PSS_VEC_RTC       12'h018

// Start-up time in system clock periods; the core clock is the system clock
`define PSS_SST_TSYS      1024
`define PSS_SST_CYCLES    (`PSS_SST_TSYS * 1)

`endif

// File: pss_program_sequencer.v
`timescale 1ns/1ps
`include "pss_map.vh"

module pss_program_sequencer #(
   parameter SST_CYCLES  = `PSS_SST_CYCLES,
   parameter STACK_DEPTH = `PSS_STACK_DEPTH
) (
   // Clock and reset
   input  wire        clk_i,
   input  wire        resetn_i,
   // Program memory
   output wire [11:0] rom_addr_o,
   input  wire [14:0] rom_data_i,
   // Instruction to decoder
   output reg  [14:0] instr_o,
   output wire        instr_valid_o,
   output wire [3:0]  phase_o,
   // Decoded controls, sampled in the last phase of an execute cycle
   input  wire        op_jump_i,
   input  wire        op_call_i,
   input  wire        return_from_call_i,
   input  wire        return_from_interrupt_i,
   input  wire        op_skip_i,
   input  wire        table_read_current_page_i,
   input  wire        table_read_last_page_i,
   input  wire        op_halt_i,
   input  wire [11:0] target_i,
   // Data-memory register port
   input  wire [7:0]  reg_addr_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   output reg         reg_hit_o,
   // Table read result
   output reg  [7:0]  tbl_low_o,
   output reg         tbl_low_valid_o,
   // Interrupts
   input  wire [5:0]  irq_req_i,
   input  wire [5:0]  irq_en_i,
   input  wire        gie_set_i,
   input  wire        gie_clr_i,
   output reg  [5:0]  irq_ack_o,
   output wire        global_irq_enable_o,
   // Halt and wake-up
   input  wire        wake_i,
   output wire        halted_o
);

   // Pipeline state
   reg  [1:0]  phase_r;
   reg  [11:0] program_counter_r;
   reg         ir_valid_r;

   // Table unit
   reg         tbl_cyc_r;
   reg  [11:0] tbl_addr_r;
   reg  [7:0]  table_pointer_reg_r;
   reg  [7:0]  table_high_byte_r;

   // Interrupt enable, halt and start-up
   reg         global_irq_enable_r;
   reg         halted_r;
   reg  [10:0] sst_cnt_r;

   // Return stack: occupancy and circular write pointer kept apart
   reg  [2:0]  stack_index_r;
   reg  [2:0]  stk_wp_r;
   reg  [11:0] stk_mem [0:STACK_DEPTH-1];

   // Interrupt priority encoder outputs
   reg  [11:0] irq_vec;
   reg  [5:0]  irq_onehot;

   wire        run_w     = ~halted_r & (sst_cnt_r == 11'h000);
   wire        ph3_w     = run_w & (phase_r == `PSS_PHASE_LAST);
   wire        exec_w    = ir_valid_r & ~tbl_cyc_r;
   // Twelve-bit sum has no carry out, so the top address wraps to zero
   wire [11:0] pc_inc_w  = program_counter_r + 12'h001;

   // Register decodes shared by the write and read paths; the table high byte decode feeds the read path only
   wire        sel_pcl_w  = (reg_addr_i == `PSS_ADDR_PC_LOW);
   wire        sel_table_pointer_reg_w = (reg_addr_i == `PSS_ADDR_TBL_PTR);
   wire        sel_table_high_byte_w = (reg_addr_i == `PSS_ADDR_TBL_HIGH);
   wire        pcl_wr_w   = reg_wr_i & sel_pcl_w;

   // Decoded operations; the decoder raises at most one of them
   wire        tabrd_w   = table_read_current_page_i | table_read_last_page_i;
   wire        ret_w     = return_from_call_i | return_from_interrupt_i;
   // Any of these owns the next cycle, so an interrupt waits for the boundary after it
   wire        xfer_w    = exec_w
                           & (op_jump_i
                              | op_call_i
                              | ret_w
                              | op_skip_i
                              | pcl_wr_w
                              | tabrd_w
                              | op_halt_i);
   wire        stk_full_w = (stack_index_r == STACK_DEPTH[2:0]);
   wire [5:0]  irq_pend_w = irq_req_i & irq_en_i;
   // A request stays pending while the stack is full; it is taken after a return frees a level
   wire        irq_take_w = ph3_w & ~tbl_cyc_r & ~xfer_w & global_irq_enable_r & ~stk_full_w
                            & (|irq_pend_w);
   wire        push_w    = ph3_w & ((exec_w & op_call_i) | irq_take_w);
   wire        pop_w     = ph3_w & exec_w & ret_w & ~op_call_i & ~op_jump_i;
   wire [2:0]  wp_inc_w  = (stk_wp_r == STACK_DEPTH[2:0] - 3'h1) ? 3'h0 : stk_wp_r + 3'h1;
   wire [2:0]  wp_dec_w  = (stk_wp_r == 3'h0) ? STACK_DEPTH[2:0] - 3'h1 : stk_wp_r - 3'h1;
   // Single-edge strobes for the enable and table units
   wire        return_from_interrupt_w      = ph3_w & exec_w & return_from_interrupt_i & ~op_jump_i & ~op_call_i;
   wire        tbl_start_w = ph3_w & exec_w & tabrd_w
                             & ~(op_jump_i | op_call_i | ret_w | pcl_wr_w | op_skip_i);

   // ROM address switches to the table word for one cycle only
   assign rom_addr_o          = tbl_cyc_r ? tbl_addr_r : program_counter_r;
   assign instr_valid_o       = run_w & exec_w;
   assign phase_o             = run_w ? (4'h1 << phase_r) : 4'h0;
   assign global_irq_enable_o = global_irq_enable_r;
   assign halted_o            = halted_r;

   // Fixed priority: external input zero highest, real-time clock lowest
   always @* begin
      irq_onehot = 6'h00;
      irq_vec    = `PSS_VEC_RESET;
      if (irq_pend_w[0]) begin
         irq_onehot = 6'h01;
         irq_vec    = `PSS_VEC_EXT0;
      end else if (irq_pend_w[1]) begin
         irq_onehot = 6'h02;
         irq_vec    = `PSS_VEC_EXT1;
      end else if (irq_pend_w[2]) begin
         irq_onehot = 6'h04;
         irq_vec    = `PSS_VEC_TMR0;
      end else if (irq_pend_w[3]) begin
         irq_onehot = 6'h08;
         irq_vec    = `PSS_VEC_TMR1;
      end else if (irq_pend_w[4]) begin
         irq_onehot = 6'h10;
         irq_vec    = `PSS_VEC_TBASE;
      end else if (irq_pend_w[5]) begin
         irq_onehot = 6'h20;
         irq_vec    = `PSS_VEC_RTC;
      end
   end

   // Phase counter freezes while halted or during start-up
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         phase_r <= 2'h0;
      end else if (run_w) begin
         phase_r <= phase_r + 2'h1;
      end
   end

   // Halt latch and start-up timer; wake is honoured only while halted
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         halted_r  <= 1'b0;
         sst_cnt_r <= 11'h000;
      end else if (ph3_w & exec_w & op_halt_i) begin
         halted_r <= 1'b1;
      end else if (halted_r & wake_i) begin
         halted_r  <= 1'b0;
         sst_cnt_r <= SST_CYCLES[10:0];
      end else if (sst_cnt_r != 11'h000) begin
         sst_cnt_r <= sst_cnt_r - 11'h001;
      end
   end

   // Return stack storage; only the index and write pointer carry reset state
   always @(posedge clk_i) begin
      if (push_w) begin
         stk_mem[stk_wp_r] <= program_counter_r;
      end
   end

   // Index saturates at the depth; a call on a full stack leaves it there
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         stack_index_r <= 3'h0;
      end else if (push_w & ~stk_full_w) begin
         stack_index_r <= stack_index_r + 3'h1;
      end else if (pop_w & (stack_index_r != 3'h0)) begin
         stack_index_r <= stack_index_r - 3'h1;
      end
   end

   // Circular write: a push on a full stack overwrites the oldest entry
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         stk_wp_r <= 3'h0;
      end else if (push_w) begin
         stk_wp_r <= wp_inc_w;
      end else if (pop_w) begin
         stk_wp_r <= wp_dec_w;
      end
   end

   // Program flow: the fetch edge is the last phase of every non-table cycle
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         program_counter_r <= `PSS_VEC_RESET;
         instr_o           <= 15'h0000;
         ir_valid_r        <= 1'b0;
      end else if (ph3_w & ~tbl_cyc_r) begin
         instr_o           <= rom_data_i;
         ir_valid_r        <= 1'b1;
         program_counter_r <= pc_inc_w;
         if (irq_take_w) begin
            // The pushed address is the discarded fetch, so the return resumes it
            program_counter_r <= irq_vec;
            ir_valid_r        <= 1'b0;
         end else if (exec_w) begin
            if (op_jump_i | op_call_i) begin
               program_counter_r <= target_i;
               ir_valid_r        <= 1'b0;
            end else if (ret_w) begin
               program_counter_r <= stk_mem[wp_dec_w];
               ir_valid_r        <= 1'b0;
            end else if (pcl_wr_w) begin
               program_counter_r <= {program_counter_r[11:8], reg_wdata_i};
               ir_valid_r        <= 1'b0;
            end else if (op_skip_i) begin
               // Counter still advances, so the skipped word costs PC+2
               ir_valid_r <= 1'b0;
            end
         end
      end
   end

   // Global enable: acknowledge clear and interrupt-return set outrank software
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         global_irq_enable_r <= 1'b0;
      end else if (irq_take_w) begin
         global_irq_enable_r <= 1'b0;
      end else if (return_from_interrupt_w) begin
         global_irq_enable_r <= 1'b1;
      end else if (gie_set_i) begin
         global_irq_enable_r <= 1'b1;
      end else if (gie_clr_i) begin
         global_irq_enable_r <= 1'b0;
      end
   end

   // Acknowledge pulse lets the source clear its own request flag
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         irq_ack_o <= 6'h00;
      end else if (irq_take_w) begin
         irq_ack_o <= irq_onehot;
      end else begin
         irq_ack_o <= 6'h00;
      end
   end

   // Table unit: one extra cycle on the table address while the pipeline holds
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         tbl_cyc_r         <= 1'b0;
         tbl_addr_r        <= 12'h000;
         table_high_byte_r <= `PSS_TBL_HIGH_RST;
         tbl_low_o         <= 8'h00;
         tbl_low_valid_o   <= 1'b0;
      end else begin
         tbl_low_valid_o <= 1'b0;
         if (ph3_w & tbl_cyc_r) begin
            table_high_byte_r <= {1'b0, rom_data_i[14:8]};
            tbl_low_o         <= rom_data_i[7:0];
            tbl_low_valid_o   <= 1'b1;
            tbl_cyc_r         <= 1'b0;
         end else if (tbl_start_w) begin
            tbl_cyc_r  <= 1'b1;
            tbl_addr_r <= {table_read_last_page_i ? `PSS_LAST_PAGE : program_counter_r[11:8],
                           table_pointer_reg_r};
         end
      end
   end

   // Table pointer takes a write on any edge; the high byte ignores writes
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         table_pointer_reg_r <= `PSS_TBL_PTR_RST;
      end else if (reg_wr_i & sel_table_pointer_reg_w) begin
         table_pointer_reg_r <= reg_wdata_i;
      end
   end

   // Register read port answers one clock after the request
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
         reg_hit_o   <= 1'b0;
      end else begin
         reg_hit_o <= reg_rd_i & (sel_pcl_w | sel_table_pointer_reg_w | sel_table_high_byte_w);
         if (reg_rd_i) begin
            case (reg_addr_i)
               `PSS_ADDR_PC_LOW:   reg_rdata_o <= program_counter_r[7:0];
               `PSS_ADDR_TBL_PTR:  reg_rdata_o <= table_pointer_reg_r;
               `PSS_ADDR_TBL_HIGH: reg_rdata_o <= table_high_byte_r;
               default:            reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end

endmodule

// File: pss_rom_model.sv
`timescale 1ns/1ps
module pss_rom_model (
   // Program memory port
   input  wire [11:0] addr_i,
   output wire [14:0] data_o
);
   // Each word carries its own address so any misrouted fetch is visible
   assign data_o = {3'h5, addr_i};
endmodule
